/* File: mcal_pkg.sv */
package mcal_pkg;

    // Clock rate and die temperature sampling interval
    localparam int unsigned CLK_MHZ         = 100;
    localparam int unsigned DIE_PERIOD_US   = 10000;
    localparam int unsigned DIE_PERIOD_CYC  = DIE_PERIOD_US * CLK_MHZ;

    // Channel map of the measurement loop
    localparam int unsigned NCH             = 28;
    localparam int unsigned NCELL           = 14;
    localparam int unsigned NGAIN           = 18;
    localparam int unsigned NTHERM          = 9;
    localparam logic [4:0]  CH_STACK        = 5'h0E;
    localparam logic [4:0]  CH_PACK         = 5'h0F;
    localparam logic [4:0]  CH_LOAD         = 5'h10;
    localparam logic [4:0]  CH_ANALOG       = 5'h11;
    localparam logic [4:0]  CH_THERM0       = 5'h12;
    localparam logic [4:0]  CH_DIE          = 5'h1B;

    // Nominal gains for a 1.212 V reference
    localparam logic [15:0] GAIN_CELL_DFLT  = 16'h2F58;
    localparam logic [15:0] GAIN_ADC_DFLT   = 16'h0FC8;

    // Register word addresses
    localparam logic [7:0]  A_GAIN0         = 8'h00;
    localparam logic [7:0]  A_VCELL_OFF     = 8'h12;
    localparam logic [7:0]  A_VDIV_OFF      = 8'h13;
    localparam logic [7:0]  A_DIE_ROUTE     = 8'h14;
    localparam logic [7:0]  A_STATUS        = 8'h15;
    localparam logic [7:0]  A_PINCFG0       = 8'h18;
    localparam logic [7:0]  A_COEF0         = 8'h28;
    localparam logic [7:0]  A_RES0          = 8'h40;
    localparam logic [7:0]  A_RAW0          = 8'h60;
    localparam logic [7:0]  A_CELL_TEMP     = 8'h80;
    localparam logic [7:0]  A_FET_TEMP      = 8'h81;
    localparam logic [7:0]  A_DIE_TEMP      = 8'h82;
    localparam int unsigned NCOEF           = 5;

    // Pin configuration fields
    localparam int unsigned PCFG_PULL_LSB   = 0;
    localparam int unsigned PCFG_THERM_BIT  = 2;
    localparam int unsigned PCFG_FET_BIT    = 3;
    localparam logic [1:0]  PULL_NONE       = 2'h0;
    localparam logic [1:0]  PULL_18K        = 2'h1;
    localparam logic [1:0]  PULL_180K       = 2'h2;
    localparam logic [3:0]  PCFG_RST        = 4'h0;

    // Die temperature routing codes
    localparam logic [1:0]  ROUTE_NONE      = 2'h0;
    localparam logic [1:0]  ROUTE_CELL      = 2'h1;
    localparam logic [1:0]  ROUTE_FET       = 2'h2;

    // Factory load port layout
    localparam int unsigned FACT_GAIN_BIT   = 5;
    localparam logic [4:0]  FACT_R18K_IDX   = 5'h1E;
    localparam logic [4:0]  FACT_R180K_IDX  = 5'h1F;

    // One raw sample from the voltage ADC
    typedef struct packed {
        logic [4:0]  ch;
        logic [31:0] raw;
    } mcal_smp_s;

    // One factory trim word
    typedef struct packed {
        logic [5:0]  addr;
        logic [31:0] data;
    } mcal_fact_s;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_TRIM,
        ST_SCALE,
        ST_PULL,
        ST_POLY,
        ST_STORE
    } mcal_state_e;

endpackage : mcal_pkg

/* File: mcal_top.sv */
// How it works
// - Die temperature sampled periodically, readable by host.
// - Die temperature routes to cell or FET.
// - Nine pins may measure thermistors.
// - Per pin pullup 18k, 180k or none.
// - Stored measured pullup values scale thermistor readings.
// - Pin config: thermistor, pullup, cell or FET.
// - Programmable polynomial turns voltage into temperature.
// - Raw count report is offset trimmed only.
// - Factory gain trim on analog, thermistor, divider channels.
// - Each of 14 cells has own gain.
// - Separate gains for stack, pack, load, analog.
// - Written calibration gain overrides factory trim.
// - Order: trim offset, gain, then user offset.
// - Cell and divider: gain times count, minus offset.
// - Analog input: gain times count, no offset.
// - Cells in mV, dividers in user units.
// - Outside config update, full access reads show factory or nominal gain if unwritten.
// - Config update: cell gain reads zero unless written.
// - After config update reads show gains in use, unwritten cell gains zero unless full access.
// - Cell range 5x reference, analog 1.667x reference.
// - Defaults 12120 cells, 4040 analog inputs.
// - Every input reported as scaled value and raw.
`timescale 1ns/1ps

module mcal_top #(
    parameter int unsigned DIE_PERIOD_CYC = mcal_pkg::DIE_PERIOD_CYC
) (
    // Clock and reset
    input  wire logic               i_ref_clk,
    input  wire logic               i_srst,
    // Register port
    input  wire logic [7:0]         i_addr,
    input  wire logic [31:0]        i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    output logic [31:0]             o_rdata,
    // Access modes
    input  wire logic               i_unrestricted_access_mode,
    input  wire logic               i_cfg_update,
    // Factory trim load
    input  wire logic               i_fact_we,
    input  wire mcal_pkg::mcal_fact_s i_fact,
    // Raw samples from the ADC
    input  wire logic               i_smp_valid,
    input  wire mcal_pkg::mcal_smp_s  i_smp,
    output logic                    o_smp_ready,
    // Measurement loop requests
    output logic                    o_die_req,
    // Thermistor bias switches, one bit per pin
    output logic [8:0]              o_pull_18k,
    output logic [8:0]              o_pull_180k,
    // Temperatures for protection logic
    output logic [15:0]             o_cell_temp,
    output logic [15:0]             o_fet_temp,
    output logic [15:0]             o_die_temp,
    // Result strobe
    output logic                    o_res_valid,
    output logic [4:0]              o_res_ch,
    output logic [15:0]             o_res_data
);

    // Factory trim storage
    logic [31:0]            fact_off_reg  [mcal_pkg::NCH];   // Offset trim per channel
    logic [15:0]            fact_gain_reg [mcal_pkg::NCH];   // Gain trim per channel
    logic [mcal_pkg::NCH-1:0] fact_vld_reg;                  // Gain trim present
    logic [15:0]            r18k_reg;                        // Measured 18k pullup
    logic [15:0]            r180k_reg;                       // Measured 180k pullup
    // Customer calibration
    logic [15:0]            cal_gain_reg  [mcal_pkg::NGAIN]; // Cells, stack, pack, load, analog
    logic [mcal_pkg::NGAIN-1:0] cal_wr_reg;                  // Written since reset
    logic [15:0]            vcell_off_reg;                   // Cell offset, mV
    logic [15:0]            vdiv_off_reg;                    // Divider offset, user units
    logic [1:0]             die_route_reg;                   // Die temp destination
    logic [3:0]             pincfg_reg    [mcal_pkg::NTHERM];// Pin setup
    logic [15:0]            coef_reg      [mcal_pkg::NCOEF]; // Polynomial coefficients
    // Results
    logic [15:0]            res_reg       [mcal_pkg::NCH];   // Scaled results
    logic [31:0]            raw_reg       [mcal_pkg::NCH];   // Offset trimmed counts
    // Sequencer
    mcal_pkg::mcal_state_e  st_reg;
    mcal_pkg::mcal_state_e  st_next;
    logic [4:0]             ch_reg;
    logic [31:0]            smp_raw_reg;
    logic [31:0]            adj_reg;
    logic [15:0]            val_reg;
    logic [15:0]            acc_reg;
    logic [1:0]             pidx_reg;
    logic [31:0]            die_cnt_reg;

    // Map a channel to its calibration gain slot
    // own divider and analog slots
    function automatic logic [4:0] gain_slot(input logic [4:0] ch);
        gain_slot = (ch < mcal_pkg::CH_THERM0) ? ch : mcal_pkg::CH_ANALOG;
    endfunction : gain_slot

    // True for a thermistor capable pin channel
    // nine pin channels
    function automatic logic is_pin(input logic [4:0] ch);
        is_pin = (ch >= mcal_pkg::CH_THERM0) && (ch < mcal_pkg::CH_DIE);
    endfunction : is_pin

    // Gain in use: calibration, then factory, then nominal
    // written gain wins
    function automatic logic [15:0] gain_used(input logic [4:0] ch);
        logic [4:0] s;
        s = gain_slot(ch);
        if (cal_wr_reg[s])
            gain_used = cal_gain_reg[s];
        else if (fact_vld_reg[ch])
            gain_used = fact_gain_reg[ch];
        else if (ch < mcal_pkg::CH_ANALOG)
            gain_used = mcal_pkg::GAIN_CELL_DFLT;
        else
            gain_used = mcal_pkg::GAIN_ADC_DFLT;
    endfunction : gain_used

    // Channel decode
    wire logic [3:0]  pin_idx   = 4'(ch_reg - mcal_pkg::CH_THERM0);
    wire logic        ch_pin    = is_pin(ch_reg);
    wire logic [3:0]  cur_cfg   = ch_pin ? pincfg_reg[pin_idx] : mcal_pkg::PCFG_RST;
    wire logic        ch_therm  = ch_pin && cur_cfg[mcal_pkg::PCFG_THERM_BIT];
    wire logic [1:0]  cur_pull  = cur_cfg[mcal_pkg::PCFG_PULL_LSB +: 2];
    wire logic        ch_cell   = ch_reg < 5'(mcal_pkg::NCELL);
    wire logic        ch_div    = (ch_reg >= mcal_pkg::CH_STACK) && (ch_reg <= mcal_pkg::CH_LOAD);
    wire logic [15:0] pull_val  = (cur_pull == mcal_pkg::PULL_180K) ? r180k_reg : r18k_reg;
    wire logic [15:0] user_off  = ch_cell ? vcell_off_reg : (ch_div ? vdiv_off_reg : 16'h0000);

    // Shared multiplier, operands chosen by state
    logic signed [31:0] mul_a;
    logic signed [31:0] mul_b;
    logic signed [31:0] prod;
    always_comb
    begin
        mul_a = 32'sh0000_0000;
        mul_b = 32'sh0000_0000;
        unique case (st_reg)
            mcal_pkg::ST_SCALE:
            begin
                mul_a = $signed({16'h0000, gain_used(ch_reg)});
                mul_b = $signed({{16{adj_reg[15]}}, adj_reg[15:0]});
            end
            mcal_pkg::ST_PULL:
            begin
                mul_a = $signed({{16{val_reg[15]}}, val_reg});
                mul_b = $signed({16'h0000, pull_val});
            end
            mcal_pkg::ST_POLY:
            begin
                mul_a = $signed({{16{acc_reg[15]}}, acc_reg});
                mul_b = $signed({{16{val_reg[15]}}, val_reg});
            end
            default:
            begin
                mul_a = 32'sh0000_0000;
                mul_b = 32'sh0000_0000;
            end
        endcase
    end
    assign prod = mul_a * mul_b;

    wire logic [15:0] prod_hi   = prod[31:16];
    wire logic [15:0] scaled    = 16'(prod_hi - user_off);
    wire logic [15:0] poly_step = 16'(prod_hi + coef_reg[pidx_reg]);
    wire logic [15:0] final_val = ch_therm ? acc_reg : val_reg;

    // Next state of the correction sequencer
    always_comb
    begin
        st_next = st_reg;
        unique case (st_reg)
            mcal_pkg::ST_IDLE:
                if (i_smp_valid)
                    st_next = mcal_pkg::ST_TRIM;
            mcal_pkg::ST_TRIM:
                st_next = mcal_pkg::ST_SCALE;
            mcal_pkg::ST_SCALE:
                if (!ch_therm)
                    st_next = mcal_pkg::ST_STORE;
                else if (cur_pull != mcal_pkg::PULL_NONE)
                    st_next = mcal_pkg::ST_PULL;
                else
                    st_next = mcal_pkg::ST_POLY;
            mcal_pkg::ST_PULL:
                st_next = mcal_pkg::ST_POLY;
            mcal_pkg::ST_POLY:
                if (pidx_reg == 2'h0)
                    st_next = mcal_pkg::ST_STORE;
            mcal_pkg::ST_STORE:
                st_next = mcal_pkg::ST_IDLE;
        endcase
    end

    // Sequencer state and ready flag
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            st_reg      <= mcal_pkg::ST_IDLE;
            o_smp_ready <= 1'b1;
        end
        else
        begin
            st_reg      <= st_next;
            o_smp_ready <= (st_next == mcal_pkg::ST_IDLE);
        end
    end

    // Working values of the sample in flight
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            ch_reg      <= 5'h00;
            smp_raw_reg <= 32'h0000_0000;
            adj_reg     <= 32'h0000_0000;
            val_reg     <= 16'h0000;
            acc_reg     <= 16'h0000;
            pidx_reg    <= 2'h3;
        end
        else
        begin
            if (st_reg == mcal_pkg::ST_IDLE && i_smp_valid)
            begin
                ch_reg      <= i_smp.ch;
                smp_raw_reg <= i_smp.raw;
            end
            if (st_reg == mcal_pkg::ST_TRIM)
                adj_reg <= smp_raw_reg - fact_off_reg[ch_reg];
            if (st_reg == mcal_pkg::ST_SCALE)
                val_reg <= ch_therm ? prod_hi : scaled;
            if (st_reg == mcal_pkg::ST_PULL)
                val_reg <= prod_hi;
            if (st_reg == mcal_pkg::ST_SCALE || st_reg == mcal_pkg::ST_PULL)
            begin
                acc_reg  <= coef_reg[mcal_pkg::NCOEF-1];
                pidx_reg <= 2'h3;
            end
            if (st_reg == mcal_pkg::ST_POLY)
            begin
                acc_reg  <= poly_step;
                pidx_reg <= pidx_reg - 2'h1;
            end
        end
    end

    // every channel keeps scaled and raw results
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            for (int k = 0; k < mcal_pkg::NCH; k++)
            begin
                res_reg[k] <= 16'h0000;
                raw_reg[k] <= 32'h0000_0000;
            end
        end
        else
        begin
            if (st_reg == mcal_pkg::ST_SCALE)
                raw_reg[ch_reg] <= adj_reg;
            if (st_reg == mcal_pkg::ST_STORE)
                res_reg[ch_reg] <= final_val;
        end
    end

    // Result strobe and protection temperatures
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            o_res_valid <= 1'b0;
            o_res_ch    <= 5'h00;
            o_res_data  <= 16'h0000;
            o_cell_temp <= 16'h0000;
            o_fet_temp  <= 16'h0000;
            o_die_temp  <= 16'h0000;
        end
        else
        begin
            o_res_valid <= (st_reg == mcal_pkg::ST_STORE);
            if (st_reg == mcal_pkg::ST_STORE)
            begin
                o_res_ch   <= ch_reg;
                o_res_data <= final_val;
                // pin result as cell or FET
                if (ch_therm && cur_cfg[mcal_pkg::PCFG_FET_BIT])
                    o_fet_temp <= final_val;
                else if (ch_therm)
                    o_cell_temp <= final_val;
                if (ch_reg == mcal_pkg::CH_DIE)
                begin
                    o_die_temp <= final_val;
                    if (die_route_reg == mcal_pkg::ROUTE_CELL)
                        o_cell_temp <= final_val;
                    else if (die_route_reg == mcal_pkg::ROUTE_FET)
                        o_fet_temp <= final_val;
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            die_cnt_reg <= 32'h0000_0000;
            o_die_req   <= 1'b0;
        end
        else
        begin
            o_die_req   <= (die_cnt_reg == 32'(DIE_PERIOD_CYC - 1));
            die_cnt_reg <= (die_cnt_reg == 32'(DIE_PERIOD_CYC - 1)) ? 32'h0000_0000 : die_cnt_reg + 32'h1;
        end
    end

    // factory trim load, gains for all channels
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            for (int k = 0; k < mcal_pkg::NCH; k++)
            begin
                fact_off_reg[k]  <= 32'h0000_0000;
                fact_gain_reg[k] <= 16'h0000;
            end
            fact_vld_reg <= '0;
            r18k_reg     <= 16'h0000;
            r180k_reg    <= 16'h0000;
        end
        else if (i_fact_we)
        begin
            if (!i_fact.addr[mcal_pkg::FACT_GAIN_BIT] && i_fact.addr[4:0] < 5'(mcal_pkg::NCH))
                fact_off_reg[i_fact.addr[4:0]] <= i_fact.data;
            else if (i_fact.addr[4:0] == mcal_pkg::FACT_R18K_IDX)
                r18k_reg <= i_fact.data[15:0];
            else if (i_fact.addr[4:0] == mcal_pkg::FACT_R180K_IDX)
                r180k_reg <= i_fact.data[15:0];
            else if (i_fact.addr[mcal_pkg::FACT_GAIN_BIT] && i_fact.addr[4:0] < 5'(mcal_pkg::NCH))
            begin
                fact_gain_reg[i_fact.addr[4:0]] <= i_fact.data[15:0];
                fact_vld_reg[i_fact.addr[4:0]]  <= 1'b1;
            end
        end
    end

    // Write decode
    wire logic [7:0] wr_gain = i_addr - mcal_pkg::A_GAIN0;
    wire logic [7:0] wr_pin  = i_addr - mcal_pkg::A_PINCFG0;
    wire logic [7:0] wr_coef = i_addr - mcal_pkg::A_COEF0;
    wire logic       hit_gain = i_addr < 8'(mcal_pkg::NGAIN);
    wire logic       hit_pin  = (i_addr >= mcal_pkg::A_PINCFG0) && (wr_pin < 8'(mcal_pkg::NTHERM));
    wire logic       hit_coef = (i_addr >= mcal_pkg::A_COEF0) && (wr_coef < 8'(mcal_pkg::NCOEF));

    // Software writable configuration
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            for (int k = 0; k < mcal_pkg::NGAIN; k++)
                cal_gain_reg[k] <= 16'h0000;
            for (int k = 0; k < mcal_pkg::NTHERM; k++)
                pincfg_reg[k] <= mcal_pkg::PCFG_RST;
            for (int k = 0; k < mcal_pkg::NCOEF; k++)
                coef_reg[k] <= 16'h0000;
            cal_wr_reg    <= '0;
            vcell_off_reg <= 16'h0000;
            vdiv_off_reg  <= 16'h0000;
            die_route_reg <= mcal_pkg::ROUTE_NONE;
        end
        else if (i_wr)
        begin
            // one gain per cell, divider and analog slot
            if (hit_gain)
            begin
                cal_gain_reg[wr_gain[4:0]] <= i_wdata[15:0];
                cal_wr_reg[wr_gain[4:0]]   <= 1'b1;
            end
            if (hit_pin)
                pincfg_reg[wr_pin[3:0]] <= i_wdata[3:0];
            if (hit_coef)
                coef_reg[wr_coef[2:0]] <= i_wdata[15:0];
            if (i_addr == mcal_pkg::A_VCELL_OFF)
                vcell_off_reg <= i_wdata[15:0];
            if (i_addr == mcal_pkg::A_VDIV_OFF)
                vdiv_off_reg <= i_wdata[15:0];
            if (i_addr == mcal_pkg::A_DIE_ROUTE)
                die_route_reg <= i_wdata[1:0];
        end
    end

    generate
        for (genvar g = 0; g < mcal_pkg::NTHERM; g++)
        begin : g_bias
            wire logic en = pincfg_reg[g][mcal_pkg::PCFG_THERM_BIT];
            wire logic [1:0] sel = pincfg_reg[g][mcal_pkg::PCFG_PULL_LSB +: 2];
            always_ff @(posedge i_ref_clk)
            begin
                if (i_srst)
                begin
                    o_pull_18k[g]  <= 1'b0;
                    o_pull_180k[g] <= 1'b0;
                end
                else
                begin
                    o_pull_18k[g]  <= en && (sel == mcal_pkg::PULL_18K);
                    o_pull_180k[g] <= en && (sel == mcal_pkg::PULL_180K);
                end
            end
        end
    endgenerate

    // Gain readback, mode dependent
    wire logic [4:0]  rd_slot   = wr_gain[4:0];
    wire logic        rd_cell   = rd_slot < 5'(mcal_pkg::NCELL);
    logic [15:0]      gain_rd;
    always_comb
    begin
        gain_rd = gain_used(rd_slot);
        // config update shows written cell gain or zero
        if (i_cfg_update && rd_cell)
            gain_rd = cal_wr_reg[rd_slot] ? cal_gain_reg[rd_slot] : 16'h0000;
        else if (!i_unrestricted_access_mode && rd_cell && !cal_wr_reg[rd_slot])
            gain_rd = 16'h0000;
    end

    // Read mux; unmapped addresses read zero
    logic [31:0] rd_next;
    wire logic [7:0] rd_res = i_addr - mcal_pkg::A_RES0;
    wire logic [7:0] rd_raw = i_addr - mcal_pkg::A_RAW0;
    always_comb
    begin
        rd_next = 32'h0000_0000;
        if (hit_gain)
            rd_next = {16'h0000, gain_rd};
        else if (hit_pin)
            rd_next = {28'h000_0000, pincfg_reg[wr_pin[3:0]]};
        else if (hit_coef)
            rd_next = {16'h0000, coef_reg[wr_coef[2:0]]};
        else if (i_addr >= mcal_pkg::A_RES0 && rd_res < 8'(mcal_pkg::NCH))
            rd_next = {16'h0000, res_reg[rd_res[4:0]]};
        else if (i_addr >= mcal_pkg::A_RAW0 && rd_raw < 8'(mcal_pkg::NCH))
            rd_next = raw_reg[rd_raw[4:0]];
        else if (i_addr == mcal_pkg::A_VCELL_OFF)
            rd_next = {16'h0000, vcell_off_reg};
        else if (i_addr == mcal_pkg::A_VDIV_OFF)
            rd_next = {16'h0000, vdiv_off_reg};
        else if (i_addr == mcal_pkg::A_DIE_ROUTE)
            rd_next = {30'h0000_0000, die_route_reg};
        else if (i_addr == mcal_pkg::A_STATUS)
            rd_next = {st_reg != mcal_pkg::ST_IDLE, 13'h0000, cal_wr_reg};
        else if (i_addr == mcal_pkg::A_CELL_TEMP)
            rd_next = {16'h0000, o_cell_temp};
        else if (i_addr == mcal_pkg::A_FET_TEMP)
            rd_next = {16'h0000, o_fet_temp};
        else if (i_addr == mcal_pkg::A_DIE_TEMP)
            rd_next = {16'h0000, o_die_temp};
    end

    // Read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
            o_rdata <= 32'h0000_0000;
        else
            o_rdata <= i_rd ? rd_next : 32'h0000_0000;
    end

endmodule : mcal_top

/* File: mcal_top_sva.sv */
`timescale 1ns/1ps
module mcal_top_sva (
    input wire logic i_ref_clk, i_srst, i_rd, i_smp_valid, o_smp_ready, o_die_req, o_res_valid,
    input wire logic [31:0] o_rdata,
    input wire logic [8:0] o_pull_18k, o_pull_180k,
    input wire logic [15:0] o_res_data,
    input wire mcal_pkg::mcal_smp_s i_smp
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    // Sample accepted by the block
    sequence s_take; i_smp_valid && o_smp_ready; endsequence
    a_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000) else $error("rdata not idle");
    a_take_busy: assert property (s_take |=> !o_smp_ready [*3]) else $error("ready after take");
    a_cell_lat: assert property (s_take ##0 i_smp.ch < 5'h0E |-> ##[4:5] o_res_valid) else $error("late");
    a_res_pulse: assert property (o_res_valid |=> !o_res_valid) else $error("long strobe");
    a_res_idle: assert property (o_res_valid |-> o_smp_ready) else $error("result while busy");
    a_res_hold: assert property (o_res_valid |=> $stable(o_res_data) [*2]) else $error("result moved");
    a_pull_excl: assert property ((o_pull_18k & o_pull_180k) == 9'h000) else $error("both pullups");
    a_die_gap: assert property (o_die_req |=> !o_die_req [*8]) else $error("die request burst");
endmodule : mcal_top_sva
bind mcal_top mcal_top_sva u_mcal_top_sva (.*);

/* File: mcal_adc_model.sv */
`timescale 1ns/1ps
module mcal_adc_model (input wire logic i_ref_clk, i_ready, output logic o_valid, output mcal_pkg::mcal_smp_s o_smp);
    initial {o_valid, o_smp} = '0;
    // Offer right after an edge, gap cycles later, hold until taken; released bus shows the inverse
    task automatic send(input logic [4:0] c, input logic [31:0] r, input int gap);
        repeat (gap + 1) @(posedge i_ref_clk);
        {o_valid, o_smp} <= {1'b1, c, r};
        do @(negedge i_ref_clk); while (!i_ready);
        @(posedge i_ref_clk);
        {o_valid, o_smp} <= {1'b0, ~c, ~r};
    endtask : send
endmodule : mcal_adc_model

/* File: mcal_top_bench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; $display("BAD %0t got %h want %h", $time, a, b); end end
module mcal_top_bench;
    logic clk, i_srst, i_wr, i_rd, full, i_cfg_update, i_fact_we, i_smp_valid, o_smp_ready, o_die_req, o_res_valid;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic [8:0] o_pull_18k, o_pull_180k;
    logic [15:0] o_cell_temp, o_fet_temp, o_die_temp, o_res_data;
    logic [4:0] o_res_ch;
    mcal_pkg::mcal_fact_s i_fact;
    mcal_pkg::mcal_smp_s i_smp;
    int num_errors = 0;
    int checks = 0;
    // Short die period keeps the run brief
    mcal_top #(.DIE_PERIOD_CYC(20)) u_mcal_top (.i_ref_clk(clk), .i_unrestricted_access_mode(full), .*);
    mcal_adc_model u_mcal_adc_model (.i_ref_clk(clk), .i_ready(o_smp_ready), .o_valid(i_smp_valid), .o_smp(i_smp));
    initial forever #5 clk = ~clk;
    // Register write, or factory trim load when f is set
    task automatic wreg(input logic f, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {i_fact_we, i_wr, i_addr, i_wdata, i_fact} <= {f, !f, a, d, a[5:0], d};
        @(posedge clk);
        {i_fact_we, i_wr} <= 2'b00;
    endtask : wreg
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        {i_rd, i_addr} <= {1'b1, a};
        @(posedge clk);
        i_rd <= 1'b0;
        #1 `CHK(o_rdata, e)
    endtask : rchk
    // Gap of the offer follows the channel, so the source is slow at times
    task automatic schk(input logic [4:0] c, input logic [31:0] r, input logic [15:0] e);
        u_mcal_adc_model.send(c, r, int'(c[1:0]));
        for (int i = 0; i < 16 && o_res_valid !== 1'b1; i++) @(negedge clk);
        `CHK({o_res_valid, o_res_ch, o_res_data}, {1'b1, c, e})
    endtask : schk
    task automatic tally_and_finish;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (2000) @(posedge clk);
        num_errors++;
        tally_and_finish;
    end
    task automatic t_gains;
        wreg(1'b1, 8'h21, 32'h0000_3000);
        full <= 1'b1;
        rchk(8'h00, {16'h0000, mcal_pkg::GAIN_CELL_DFLT});
        rchk(8'h01, 32'h0000_3000);
        rchk(8'h11, {16'h0000, mcal_pkg::GAIN_ADC_DFLT});
        @(posedge clk);
        {full, i_cfg_update} <= 2'b01;
        rchk(8'h01, 32'h0000_0000);
        rchk(8'h00, 32'h0000_0000);
        wreg(1'b0, 8'h00, 32'h0000_2000);
        rchk(8'h00, 32'h0000_2000);
        @(posedge clk);
        i_cfg_update <= 1'b0;
        rchk(8'h00, 32'h0000_2000);
        rchk(8'h05, 32'h0000_0000);
        rchk(8'h3F, 32'h0000_0000);
    endtask : t_gains
    // Trim, gain, offsets and a negative count
    task automatic t_meas;
        wreg(1'b1, 8'h00, 32'h0000_0010);
        wreg(1'b0, 8'h12, 32'h0000_0005);
        schk(5'h00, 32'h0000_1000, 16'h01F9);
        rchk(8'h60, 32'h0000_0FF0);
        wreg(1'b1, 8'h2E, 32'h0000_2000);
        wreg(1'b0, 8'h13, 32'h0000_0003);
        schk(5'h0E, 32'h0000_1000, 16'h01FD);
        schk(5'h11, 32'h0000_4000, 16'h03F2);
        schk(5'h11, 32'hFFFF_F000, 16'hFF03);
    endtask : t_meas
    // Measured pullups and two coefficients so each step shows in the result
    task automatic t_therm;
        wreg(1'b1, 8'h1E, 32'h0000_8000);
        wreg(1'b1, 8'h1F, 32'h0000_4000);
        wreg(1'b0, 8'h18, 32'h0000_0005);
        wreg(1'b0, 8'h19, 32'h0000_000E);
        wreg(1'b0, 8'h28, 32'h0000_0007);
        wreg(1'b0, 8'h29, 32'h0000_2000);
        `CHK({o_pull_180k, o_pull_18k}, {9'h002, 9'h001})
        schk(5'h12, 32'h0000_1000, 16'h0016);
        schk(5'h13, 32'h0000_1000, 16'h000E);
        `CHK({o_cell_temp, o_fet_temp}, {16'h0016, 16'h000E})
    endtask : t_therm
    // Die reading routed to the FET temperature
    task automatic t_die;
        wreg(1'b0, 8'h14, 32'h0000_0002);
        for (int i = 0; i < 24 && o_die_req !== 1'b1; i++) @(negedge clk);
        `CHK(o_die_req, 1'b1)
        schk(5'h1B, 32'h0000_2000, 16'h01F9);
        `CHK({o_die_temp, o_fet_temp, o_cell_temp}, {16'h01F9, 16'h01F9, 16'h0016})
        rchk(8'h82, 32'h0000_01F9);
    endtask : t_die
    initial
    begin
        {clk, i_wr, i_rd, full, i_cfg_update, i_fact_we, i_addr, i_wdata, i_fact} = '0;
        i_srst = 1'b1;
        repeat (5) @(posedge clk);
        i_srst <= 1'b0;
        t_gains;
        t_meas;
        t_therm;
        t_die;
        tally_and_finish;
    end
endmodule : mcal_top_bench
